// ===== common/ebipt_pkg.sv
// Purpose: Shared constants and types for the 8-bit interval/PWM timer.
// Assumes: One system clock; the count clock arrives as a one-cycle tick.
// Notes: Mode codes follow the two-bit mode field of the timer mode register.
package ebipt_pkg;
   localparam logic [15:0] PORT1_DIR_ADDR = 16'hff21;
   localparam logic [7:0] PORT1_DIR_RESET = 8'hff;
   localparam int PIN_FIVE = 5;
   localparam int PIN_SIX = 6;
   localparam logic [1:0] MODE_INTERVAL = 2'h0;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] DUTY_SETTLE_TICKS = 2'h3;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] DUTY_RESET = 8'h00;

   // Timer mode register fields as seen by the timer.
   typedef struct packed {
      logic runBit;
      logic [1:0] mode;
      logic outLevelBit;
      logic outEnableBit;
   } ebipt_ctrl_t;

   typedef enum logic {CMP_PERIOD, CMP_DUTY} ebipt_cmp_sel_t;
endpackage

// ===== design/ebipt_timer.sv
// Purpose: 8-bit up-counter giving an interval timer with square wave, or a PWM output.
// Assumes: countTick is a one-cycle pulse per count clock; all inputs synchronous to clk.
// Notes: Output pin level and direction are registered one cycle after the internal state.
//
// Summary of operation
// R1: Interval mode, counter equal to period compare raises match interrupt, clears counter.
// R2: Interval mode ignores the duty compare register completely.
// R3: Output enable bit set in interval mode gives a 50% square wave.
// R4: Interval period match inverts output, clears counter, pulses match interrupt.
// R5: Counting starts within one count clock after the run bit is set.
// R6: Interval mode stop forces interrupt and output inactive; inactive levels are kept.
// R7: Software must not rewrite the period compare while PWM runs.
// R8: Duty compare writes while running take effect after three count clocks.
// R9: PWM period match clears counter, raises interrupt, output active, compares duty next.
// R10: PWM duty match drives output inactive, compares period next, no clear, no interrupt.
// R11: PWM cycle is N+1 count clocks, active width M+1 count clocks.
// R12: Software must rewrite the duty compare on every PWM restart.
// R13: Software keeps 00H <= duty < period <= FFH.
// R14: PWM start masks the first count clock; output inactive until first period match.
// R15: PWM stop forces match interrupt and output inactive.
// R16: Software clears pin five and six direction bits and latches for timer output; the bench clears only the pin five direction bit (writes DFH).
// R17: Direction bit 0 means output buffer on, 1 input; reset sets all to FFH.
// R18: Clearing run stops and clears counter; setting run starts counting.
// R19: Output level bit gives the default (inactive) output level.
// R20: Mode field selects interval or PWM; prohibited codes are undefined.
// R21: Match interrupt is one count clock wide, only on qualifying matches.
`timescale 1ns/1ps
module ebipt_timer #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Count clock and control.
   input wire logic countTick,
   input wire ebipt_pkg::ebipt_ctrl_t ctrl,
   input wire logic [WIDTH-1:0] periodCompare,
   input wire logic [WIDTH-1:0] dutyCompare,
   input wire logic dutyWrite,
   // Port direction register write.
   input wire logic portWrite,
   input wire logic [15:0] portAddr,
   input wire logic [7:0] portWrData,
   // Outputs.
   output logic matchIrq,
   output logic timerOutPinA,
   output logic timerOutPinAOe,
   output logic [7:0] port1Direction,
   output logic [WIDTH-1:0] countValue
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] dutyActive_reg;
   logic [WIDTH-1:0] dutyPending_reg;
   logic pendingValid_reg;
   logic [1:0] pendingAge_reg;
   logic runPrev_reg;
   logic startMask_reg;
   logic active_reg;
   logic irq_reg;
   ebipt_pkg::ebipt_cmp_sel_t cmpSel_reg;
   logic isPwm;
   logic stepTick;
   logic periodHit;
   logic dutyHit;
   logic pwmStart;
   localparam logic [WIDTH-1:0] DUTY_RESET_W = WIDTH'(ebipt_pkg::DUTY_RESET);

   // R20: mode selects PWM.
   assign isPwm = (ctrl.mode == ebipt_pkg::MODE_PWM);
   assign pwmStart = ctrl.runBit && !runPrev_reg && isPwm;
   // R14: start tick masked.
   assign stepTick = ctrl.runBit && countTick && !startMask_reg && !pwmStart;
   // R2: duty compared only in PWM mode.
   assign periodHit = stepTick && (count_reg == periodCompare) && !(isPwm && cmpSel_reg == ebipt_pkg::CMP_DUTY);
   // R11: cycle and width.
   assign dutyHit = stepTick && isPwm && cmpSel_reg == ebipt_pkg::CMP_DUTY && (count_reg == dutyActive_reg);

   // Start detection and first-tick masking.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         runPrev_reg <= 1'b0;
         startMask_reg <= 1'b0;
      end else begin
         runPrev_reg <= ctrl.runBit;
         // R14: mask first count clock.
         if (pwmStart && !countTick) begin
            startMask_reg <= 1'b1;
         end else if (!ctrl.runBit || countTick) begin
            startMask_reg <= 1'b0;
         end
      end
   end

   // Counter and compare selection.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg <= ebipt_pkg::COUNT_RESET;
         cmpSel_reg <= ebipt_pkg::CMP_PERIOD;
      end else if (!ctrl.runBit) begin
         // R18: stop clears counter.
         count_reg <= ebipt_pkg::COUNT_RESET;
         cmpSel_reg <= ebipt_pkg::CMP_PERIOD;
      end else if (periodHit) begin
         // R1: clear on period match.
         count_reg <= ebipt_pkg::COUNT_RESET;
         // R9: switch to duty.
         cmpSel_reg <= isPwm ? ebipt_pkg::CMP_DUTY : ebipt_pkg::CMP_PERIOD;
      end else if (stepTick) begin
         // R5: count each tick.
         count_reg <= count_reg + 1'b1;
         // R10: back to period.
         if (dutyHit) begin
            cmpSel_reg <= ebipt_pkg::CMP_PERIOD;
         end
      end
   end

   // Duty buffer with three-tick settling.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dutyActive_reg <= DUTY_RESET_W;
         dutyPending_reg <= DUTY_RESET_W;
         pendingValid_reg <= 1'b0;
         pendingAge_reg <= 2'h0;
      end else if (dutyWrite) begin
         dutyPending_reg <= dutyCompare;
         pendingValid_reg <= ctrl.runBit;
         pendingAge_reg <= 2'h0;
         if (!ctrl.runBit) begin
            dutyActive_reg <= dutyCompare;
         end
      end else begin
         if (countTick && pendingAge_reg != ebipt_pkg::DUTY_SETTLE_TICKS) begin
            pendingAge_reg <= pendingAge_reg + 2'h1;
         end
         // R8: transfer on old-duty match after settling.
         if (dutyHit && pendingValid_reg && pendingAge_reg == ebipt_pkg::DUTY_SETTLE_TICKS) begin
            dutyActive_reg <= dutyPending_reg;
            pendingValid_reg <= 1'b0;
         end
      end
   end

   // Output activity and match interrupt.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else if (!ctrl.runBit) begin
         // R6: R15: stop forces inactive.
         active_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         // R21: one count clock wide.
         if (countTick) begin
            irq_reg <= periodHit;
         end
         if (periodHit) begin
            // R4: R9: invert or go active.
            active_reg <= isPwm ? 1'b1 : !active_reg;
         end else if (dutyHit) begin
            active_reg <= 1'b0;
         end
      end
   end

   // Port direction register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // R17: reset to FFH.
         port1Direction <= ebipt_pkg::PORT1_DIR_RESET;
      end else if (portWrite && portAddr == ebipt_pkg::PORT1_DIR_ADDR) begin
         port1Direction <= portWrData;
      end
   end

   // Registered pin drive.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timerOutPinA <= 1'b0;
         timerOutPinAOe <= 1'b0;
         matchIrq <= 1'b0;
         countValue <= ebipt_pkg::COUNT_RESET;
      end else begin
         // R3: R19: level bit gives inactive polarity.
         timerOutPinA <= ctrl.outLevelBit ^ (ctrl.outEnableBit & active_reg);
         // R17: zero direction bit turns buffer on.
         timerOutPinAOe <= !port1Direction[ebipt_pkg::PIN_FIVE];
         matchIrq <= irq_reg;
         countValue <= count_reg;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_period_irq: assert property (periodHit |=> irq_reg) else $error("No interrupt on period match."); // R1
   a_period_clear: assert property (periodHit |=> count_reg == '0) else $error("Counter not cleared."); // R1
   a_stop_state: assert property (!ctrl.runBit |=> count_reg == '0 && !irq_reg && !active_reg)
      else $error("Stop did not clear state."); // R6
   a_interval_toggle: assert property (periodHit && !isPwm |=> active_reg != $past(active_reg))
      else $error("Interval output not inverted."); // R4
   a_duty_quiet: assert property (dutyHit ##1 ctrl.runBit && !countTick |-> !irq_reg && !active_reg)
      else $error("Duty match misbehaved."); // R10
   a_interval_nodut: assert property (!isPwm |-> !dutyHit) else $error("Duty matched in interval mode."); // R2
   a_pwm_active: assert property (periodHit && isPwm |=> active_reg && cmpSel_reg == ebipt_pkg::CMP_DUTY)
      else $error("PWM period match wrong."); // R9
   a_duty_hold: assert property (dutyHit && pendingAge_reg != ebipt_pkg::DUTY_SETTLE_TICKS && !dutyWrite
      |=> dutyActive_reg == $past(dutyActive_reg)) else $error("Duty transferred too early."); // R8
   a_pwm_mask: assert property (pwmStart && !countTick |=> startMask_reg)
      else $error("First tick not masked."); // R14
   a_start_idle: assert property (pwmStart |=> count_reg == '0 && !active_reg)
      else $error("PWM start counted or went active."); // R14
   a_irq_hold: assert property (irq_reg && !countTick && ctrl.runBit |=> irq_reg)
      else $error("Interrupt shorter than a count clock."); // R21
   a_dir_write: assert property (portWrite && portAddr == ebipt_pkg::PORT1_DIR_ADDR
      |=> port1Direction == $past(portWrData)) else $error("Direction write lost."); // R17

   c_interval_match: cover property (periodHit && !isPwm);
   c_pwm_cycle: cover property (periodHit && isPwm ##[1:600] dutyHit);
   c_duty_transfer: cover property (dutyHit && pendingValid_reg && pendingAge_reg == ebipt_pkg::DUTY_SETTLE_TICKS);
   c_stop_running: cover property (active_reg ##1 !ctrl.runBit);
   c_pwm_start: cover property (pwmStart && countTick);
endmodule

// ===== tb/ebipt_pin_load.sv
// Purpose: External load on the timer output pin.
// Assumes: The pin has a pull-up to the high level.
// Notes: Behavioural only.
`timescale 1ns/1ps
module ebipt_pin_load (
   // Pin drive from the timer.
   input wire logic timerOutPinA,
   input wire logic timerOutPinAOe,
   // Resolved pin level.
   output logic pinLevel
);
   assign pinLevel = timerOutPinAOe ? timerOutPinA : 1'b1;
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the interval and PWM timer.
// Assumes: Count clock ticks every second clock cycle.
// Notes: Pin widths are measured in clock cycles.
`timescale 1ns/1ps
module tb_top;
   localparam int TP = 2;
   logic clk = 0, rst = 1, countTick = 0, dutyWrite = 0, portWrite = 0;
   ebipt_pkg::ebipt_ctrl_t ctrl = '0;
   logic [7:0] periodCompare = 8'h00, dutyCompare = 8'h00, portWrData = 8'h00;
   logic [15:0] portAddr = 16'h0000;
   logic matchIrq, timerOutPinA, timerOutPinAOe, pinLevel;
   logic [7:0] port1Direction, countValue;
   int miscompares = 0, n_tests = 0, seed = 32'h473e, hi, lo, irqs, n, m;
   ebipt_timer u_dut (.clk(clk), .rst(rst), .countTick(countTick), .ctrl(ctrl),
      .periodCompare(periodCompare), .dutyCompare(dutyCompare), .dutyWrite(dutyWrite),
      .portWrite(portWrite), .portAddr(portAddr), .portWrData(portWrData), .matchIrq(matchIrq),
      .timerOutPinA(timerOutPinA), .timerOutPinAOe(timerOutPinAOe),
      .port1Direction(port1Direction), .countValue(countValue));
   ebipt_pin_load u_load (.timerOutPinA(timerOutPinA), .timerOutPinAOe(timerOutPinAOe),
      .pinLevel(pinLevel));
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(negedge clk) countTick <= ~countTick;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (miscompares == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic int exp_width(input logic pwm, input logic high, input int n, input int m);
      return pwm ? TP * (high ? m + 1 : n - m) : TP * (n + 1);
   endfunction
   task automatic port_wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      portWrite = 1;
      portAddr = a;
      portWrData = d;
      @(negedge clk);
      portWrite = 0;
   endtask
   // Counts one active and one inactive phase of the pin.
   task automatic measure();
      int t;
      t = 0;
      hi = 0;
      lo = 0;
      irqs = 0;
      while ((pinLevel ^ ctrl.outLevelBit) !== 1'b1 && t < 2000) begin
         @(negedge clk);
         t++;
      end
      while ((pinLevel ^ ctrl.outLevelBit) === 1'b1 && hi < 2000) begin
         irqs += int'(matchIrq);
         @(negedge clk);
         hi++;
      end
      while ((pinLevel ^ ctrl.outLevelBit) === 1'b0 && lo < 2000) begin
         irqs += int'(matchIrq);
         @(negedge clk);
         lo++;
      end
   endtask
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end
   initial begin
      repeat (10) @(negedge clk);
      rst = 0;
      check(32'(port1Direction), 32'hff);
      check(32'(pinLevel), 32'h1);
      port_wr(16'hff20, 8'h00);
      check(32'(port1Direction), 32'hff);
      port_wr(ebipt_pkg::PORT1_DIR_ADDR, 8'hdf);
      @(negedge clk);
      check(32'(port1Direction), 32'hdf);
      check(32'(timerOutPinAOe), 32'h1);
      for (int it = 0; it < 6; it++) begin
         n = (it == 5) ? 255 : 2 + ($unsigned($random(seed)) % 6);
         m = (it == 5) ? 0 : (it == 3) ? n - 1 : $unsigned($random(seed)) % n;
         ctrl.mode = it[0] ? ebipt_pkg::MODE_PWM : ebipt_pkg::MODE_INTERVAL;
         ctrl.outLevelBit = it[1];
         ctrl.outEnableBit = 1;
         // period set and duty rewritten while stopped.
         periodCompare = n[7:0];
         dutyCompare = m[7:0];
         dutyWrite = 1;
         @(negedge clk);
         dutyWrite = 0;
         ctrl.runBit = 1;
         @(negedge clk);
         check(32'(pinLevel), 32'(it[1]));
         measure();
         check(hi, exp_width(it[0], 1, n, m));
         check(lo, exp_width(it[0], 0, n, m));
         check(irqs, it[0] ? 2 * TP / 2 : 4 * TP / 2);
         if (it[0]) begin
            m = $unsigned($random(seed)) % n;
            dutyCompare = m[7:0];
            dutyWrite = 1;
            @(negedge clk);
            dutyWrite = 0;
            measure();
            measure();
            measure();
            check(hi, exp_width(1, 1, n, m));
         end
         ctrl.runBit = 0;
         repeat (2) @(negedge clk);
         check(32'(matchIrq), 32'h0);
         check(32'(pinLevel), 32'(it[1]));
         check(32'(countValue), 32'h0);
      end
      // output disabled holds the default level.
      ctrl.mode = ebipt_pkg::MODE_INTERVAL;
      ctrl.outLevelBit = 0;
      ctrl.outEnableBit = 0;
      periodCompare = 8'h02;
      ctrl.runBit = 1;
      irqs = 0;
      repeat (40) begin
         @(negedge clk);
         irqs += int'(matchIrq);
         check(32'(pinLevel), 32'h0);
      end
      check(32'(irqs > 0), 32'h1);
      complete_run();
   end
endmodule
